//--- core/reset_pin_sequencer.sv
// reset pin sequencer with axi4-lite register slave
//
// Added by the designer: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module reset_pin_sequencer
  import rst_seq_pkg::*;
#(
  parameter int min_drive = min_drive_cycles
)
(
  // clock, power-on reset, enable
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        clk_en,
  // axi4-lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // reset pin, open drain
  input  wire logic        reset_pin_in,
  output logic             reset_pin_out,
  output logic             reset_pin_oe,
  // flash and option word
  input  wire logic        flash_init_done,
  input  wire logic        option_loaded,
  input  wire logic        reset_pin_cfg,
  input  wire logic        security_enabled,
  // other reset sources and power state
  input  wire logic        sys_reset_req,
  input  wire logic        low_power,
  // chip outputs
  output logic             chip_reset,
  output logic             wake_req,
  output logic             mass_erase_req,
  output logic             regulator_full,
  output logic             clk_internal_sel,
  output logic             irq
);

  // ****************************************************************
  // option latch and pin synchroniser
  // ****************************************************************
  logic             pin_en_q;
  logic             opt_done_q;
  logic             pin_s1_q;
  logic             pin_s2_q;

  // option sampled once after power-on only; system resets keep it
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_en_q   <= 1'b1;
      opt_done_q <= 1'b0;
    end
    else if (clk_en && !opt_done_q && option_loaded)
    begin
      pin_en_q   <= reset_pin_cfg;
      opt_done_q <= 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_s1_q <= 1'b1;
      pin_s2_q <= 1'b1;
    end
    else if (clk_en)
    begin
      pin_s1_q <= reset_pin_in;
      pin_s2_q <= pin_s1_q;
    end
  end

  // ****************************************************************
  // reset sequencer
  // ****************************************************************
  seq_state_e       state_q;
  logic [cnt_w-1:0] cnt_q;
  logic             soft_req_q;
  logic             erase_go;
  logic             pin_low_ev;
  logic             sys_ev;

  assign pin_low_ev = pin_en_q && opt_done_q && !pin_s2_q
                      && state_q == st_run;
  assign sys_ev     = sys_reset_req || soft_req_q || erase_go;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q <= st_drive;
      cnt_q   <= '0;
    end
    else if (clk_en)
    begin
      case (state_q)
        st_drive:
        begin
          if (cnt_q < cnt_w'(min_drive - 1))
            cnt_q <= cnt_q + 1'b1;
          else if (flash_init_done)
            state_q <= st_stretch;
          else
            state_q <= st_wait_fl;
        end
        st_wait_fl:
        begin
          if (flash_init_done)
            state_q <= st_stretch;
        end
        st_stretch:
        begin
          if (pin_s2_q || !pin_en_q)
            state_q <= st_run;
        end
        st_run:
        begin
          if (pin_low_ev || sys_ev)
          begin
            state_q <= st_drive;
            cnt_q   <= '0;
          end
        end
        default:
          state_q <= st_drive;
      endcase
    end
  end

  // pin driven low in drive and flash wait unless disabled by the option; gpio mode outside them when disabled, released otherwise
  logic [31:0] ctrl_q;
  always_comb
  begin
    if (state_q == st_drive || state_q == st_wait_fl)
    begin
      reset_pin_oe  = pin_en_q || !opt_done_q;
      reset_pin_out = 1'b0;
    end
    else if (!pin_en_q)
    begin
      reset_pin_oe  = ctrl_q[ctrl_gpio_oe_bit];
      reset_pin_out = ctrl_q[ctrl_gpio_out_bit];
    end
    else
    begin
      reset_pin_oe  = 1'b0;
      reset_pin_out = 1'b1;
    end
  end

  assign chip_reset       = state_q != st_run;
  assign regulator_full   = chip_reset;
  assign clk_internal_sel = chip_reset;
  assign wake_req         = pin_low_ev && low_power;

  // ****************************************************************
  // debug mass erase request
  // ****************************************************************
  logic [1:0] dbg_q;
  assign erase_go = dbg_q[dbg_mass_erase_bit] && dbg_q[dbg_sys_reset_bit]
                    && !pin_en_q && security_enabled;
  assign mass_erase_req = erase_go;

  // ****************************************************************
  // event flags and interrupt
  // ****************************************************************
  logic [flag_w-1:0] flag_q;
  logic [flag_w-1:0] en_q;
  logic [flag_w-1:0] set_v;
  logic [flag_w-1:0] clr_v;
  logic              wr_go;
  logic [7:0]        wr_addr;
  logic [31:0]       wdata_q;

  always_comb
  begin
    set_v = '0;
    set_v[flag_pin_bit]   = pin_low_ev;
    set_v[flag_soft_bit]  = state_q == st_run && soft_req_q;
    set_v[flag_wake_bit]  = wake_req;
    set_v[flag_erase_bit] = erase_go;
    clr_v = '0;
    if (wr_go && wr_addr == clear_addr)
      clr_v = wdata_q[flag_w-1:0];
  end

  // flags survive the chip reset so the cause can be read afterwards
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      flag_q <= '0;
    else if (clk_en)
      flag_q <= (flag_q & ~clr_v) | set_v;
  end

  assign irq = |(flag_q & en_q);

  // ****************************************************************
  // axi4-lite write side
  // ****************************************************************
  logic       aw_got_q;
  logic       w_got_q;
  logic [7:0] awaddr_q;

  assign s_axi_awready = !aw_got_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_got_q && !s_axi_bvalid;
  assign wr_go   = aw_got_q && w_got_q && !s_axi_bvalid && clk_en;
  assign wr_addr = awaddr_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_q     <= 1'b0;
      w_got_q      <= 1'b0;
      awaddr_q     <= '0;
      wdata_q      <= zero_word;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= resp_okay;
    end
    else if (clk_en)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata;
      end
      if (wr_go)
      begin
        aw_got_q     <= 1'b0;
        w_got_q      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (awaddr_q == ctrl_addr || awaddr_q == clear_addr
            || awaddr_q == enable_addr || awaddr_q == debug_addr)
          s_axi_bresp <= resp_okay;
        else
          s_axi_bresp <= resp_slverr;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // registers written by software
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_q     <= zero_word;
      en_q       <= '0;
      dbg_q      <= '0;
      soft_req_q <= 1'b0;
    end
    else if (clk_en)
    begin
      soft_req_q <= 1'b0;
      if (wr_go && awaddr_q == ctrl_addr)
      begin
        ctrl_q     <= wdata_q;
        soft_req_q <= wdata_q[ctrl_soft_rst_bit];
      end
      else if (wr_go && awaddr_q == enable_addr)
        en_q <= wdata_q[flag_w-1:0];
      else if (wr_go && awaddr_q == debug_addr)
        dbg_q <= wdata_q[1:0];
      else if (erase_go)
        dbg_q <= '0;
    end
  end

  // ****************************************************************
  // axi4-lite read side
  // ****************************************************************
  logic [31:0] rd_v;
  logic        rd_ok;

  assign s_axi_arready = !s_axi_rvalid;

  always_comb
  begin
    rd_v  = zero_word;
    rd_ok = 1'b1;
    if (s_axi_araddr == ctrl_addr)
      rd_v = ctrl_q;
    else if (s_axi_araddr == status_addr)
    begin
      rd_v[st_pin_en_bit]    = pin_en_q;
      rd_v[st_pin_level_bit] = pin_s2_q;
      rd_v[st_chip_rst_bit]  = chip_reset;
      rd_v[st_gpio_in_bit]   = pin_s2_q;
    end
    else if (s_axi_araddr == flag_addr)
      rd_v[flag_w-1:0] = flag_q;
    else if (s_axi_araddr == clear_addr)
      rd_v = zero_word;
    else if (s_axi_araddr == enable_addr)
      rd_v[flag_w-1:0] = en_q;
    else if (s_axi_araddr == debug_addr)
      rd_v[1:0] = dbg_q;
    else
      rd_ok = 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= zero_word;
      s_axi_rresp  <= resp_okay;
    end
    else if (clk_en)
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_v;
        s_axi_rresp  <= rd_ok ? resp_okay : resp_slverr;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule : reset_pin_sequencer

//--- core/rst_seq_pkg.sv
// constants for the reset pin sequencer
package rst_seq_pkg;
  // ****************************************************************
  // register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] ctrl_addr   = 8'h00;
  localparam logic [7:0] status_addr = 8'h04;
  localparam logic [7:0] flag_addr   = 8'h08;
  localparam logic [7:0] clear_addr  = 8'h0c;
  localparam logic [7:0] enable_addr = 8'h10;
  localparam logic [7:0] debug_addr  = 8'h14;
  // ****************************************************************
  // fields
  // ****************************************************************
  localparam int ctrl_soft_rst_bit   = 0;
  localparam int ctrl_gpio_oe_bit    = 1;
  localparam int ctrl_gpio_out_bit   = 2;
  localparam int st_pin_en_bit       = 0;
  localparam int st_pin_level_bit    = 1;
  localparam int st_chip_rst_bit     = 2;
  localparam int st_gpio_in_bit      = 3;
  localparam int flag_pin_bit        = 0;
  localparam int flag_soft_bit       = 1;
  localparam int flag_wake_bit       = 2;
  localparam int flag_erase_bit      = 3;
  localparam int dbg_mass_erase_bit  = 0;
  localparam int dbg_sys_reset_bit   = 1;
  localparam int flag_w              = 4;
  // ****************************************************************
  // bus answers and timing
  // ****************************************************************
  localparam logic [1:0]  resp_okay   = 2'b00;
  localparam logic [1:0]  resp_slverr = 2'b10;
  localparam logic [31:0] zero_word   = 32'h0000_0000;
  localparam int min_drive_cycles     = 128;
  localparam int cnt_w                = 8;
  // ****************************************************************
  // sequencer states
  // ****************************************************************
  typedef enum logic [3:0]
  {
    st_drive   = 4'b0001,
    st_wait_fl = 4'b0010,
    st_stretch = 4'b0100,
    st_run     = 4'b1000
  } seq_state_e;
endpackage : rst_seq_pkg

//--- tb/reset_pin_partner.sv
// outside reset circuitry on the open-drain reset pin
`timescale 1ns/1ps
module reset_pin_partner
(
  // outside party and device drive
  input  wire logic hold_low,
  input  wire logic dev_oe,
  input  wire logic dev_out,
  // resolved pin level
  output logic      pin_level
);
  // pull-up wins unless someone pulls low
  assign pin_level = !(hold_low || (dev_oe && !dev_out));
endmodule : reset_pin_partner

//--- tb/reset_pin_sequencer_assertions.sv
// checker for the reset pin sequencer ports
`timescale 1ns/1ps
module rst_seq_chk
#(
  parameter int min_drive = 8
)
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // pin and option
  input wire logic reset_pin_in,
  input wire logic reset_pin_out,
  input wire logic reset_pin_oe,
  input wire logic flash_init_done,
  input wire logic reset_pin_cfg,
  input wire logic security_enabled,
  // chip side
  input wire logic chip_reset,
  input wire logic mass_erase_req,
  input wire logic regulator_full,
  input wire logic clk_internal_sel
);
  logic [15:0] drv_q;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // cycles the device has driven the pin low in a row
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !(reset_pin_oe && !reset_pin_out))
      drv_q <= 16'h0000;
    else
      drv_q <= drv_q + 16'h0001;
  end
  a_drive_min_len: assert property ($fell(reset_pin_oe)
    && chip_reset && reset_pin_cfg |-> drv_q >= min_drive)
    else $error("pin drive too short");
  a_drive_low_value: assert property (chip_reset && reset_pin_oe
    |-> !reset_pin_out) else $error("pin not driven low in reset");
  a_hold_for_flash: assert property (chip_reset && !flash_init_done
    |=> chip_reset) else $error("reset left before flash ready");
  a_release_first: assert property ($fell(chip_reset)
    |-> !reset_pin_oe && !$past(reset_pin_oe)) else $error("reset order");
  a_stretch_hold: assert property (chip_reset && reset_pin_cfg &&
    !$past(reset_pin_in, 2) && !$past(reset_pin_in) && !reset_pin_in
    |=> chip_reset) else $error("reset left while pin low");
  a_pin_wakes: assert property (!chip_reset && reset_pin_cfg &&
    !reset_pin_oe && !reset_pin_in ##1 !reset_pin_in [*3]
    |-> ##[0:2] chip_reset) else $error("pin low did not reset");
  a_clk_internal: assert property (regulator_full == chip_reset &&
    clk_internal_sel == chip_reset) else $error("clock or regulator");
  a_erase_gate: assert property (mass_erase_req
    |-> security_enabled && !reset_pin_cfg) else $error("erase gate");
endmodule : rst_seq_chk

bind reset_pin_sequencer rst_seq_chk #(.min_drive(min_drive)) rst_seq_chk_i
(
  .aclk             (aclk),
  .aresetn          (aresetn),
  .reset_pin_in     (reset_pin_in),
  .reset_pin_out    (reset_pin_out),
  .reset_pin_oe     (reset_pin_oe),
  .flash_init_done  (flash_init_done),
  .reset_pin_cfg    (reset_pin_cfg),
  .security_enabled (security_enabled),
  .chip_reset       (chip_reset),
  .mass_erase_req   (mass_erase_req),
  .regulator_full   (regulator_full),
  .clk_internal_sel (clk_internal_sel)
);

//--- tb/testbench.sv
// register-level bench for the reset pin sequencer
`timescale 1ns/1ps
module testbench
  import rst_seq_pkg::*;
;
  localparam int          md    = 8;
  localparam logic [31:0] one_w = 32'h0000_0001;
  logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic        arvalid = 0, rready = 0, hold = 0, flash = 0, opt_ld = 0;
  logic        cfg = 1, sec = 0, lowp = 0, sysr = 0;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdat;
  logic [1:0]  resp;
  logic        awready, wready, bvalid, arready, rvalid, pin_in, pin_out;
  logic        pin_oe, crst, wake, erase, regf, clki, irq;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  int          fail_count = 0, n_tests = 0, cyc = 0, n_wake = 0, n_erase = 0;

  always #2.5 aclk = ~aclk;

  reset_pin_sequencer #(.min_drive(md)) reset_pin_sequencer_i (.aclk(aclk),
    .aresetn(aresetn), .clk_en(1'b1), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .reset_pin_in(pin_in), .reset_pin_out(pin_out),
    .reset_pin_oe(pin_oe), .flash_init_done(flash), .option_loaded(opt_ld),
    .reset_pin_cfg(cfg), .security_enabled(sec), .sys_reset_req(sysr),
    .low_power(lowp), .chip_reset(crst), .wake_req(wake),
    .mass_erase_req(erase), .regulator_full(regf),
    .clk_internal_sel(clki), .irq(irq));

  reset_pin_partner reset_pin_partner_i (.hold_low(hold), .dev_oe(pin_oe),
    .dev_out(pin_out), .pin_level(pin_in));

  // ****************************************************************
  // pulse catchers and run limit
  // ****************************************************************
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (wake)
      n_wake <= n_wake + 1;
    if (erase)
      n_erase <= n_erase + 1;
    if (cyc == 20000)
    begin
      fail_count++;
      complete_run();
    end
  end

  // ****************************************************************
  // bus and check tasks
  // ****************************************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
    end
    while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arvalid && arready)
        arvalid <= 1'b0;
    end
    while (!rvalid);
    rdat = rdata;
    resp = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask : rd

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic wt_rel;
    int n = 0;
    while (crst !== 1'b0 && n < 400)
    begin
      @(posedge aclk);
      n++;
    end
    chk(crst, 0);
  endtask : wt_rel

  task automatic pwr_up(input logic c);
    aresetn <= 1'b0;
    cfg     <= c;
    repeat (20) @(posedge aclk);
    chk({pin_oe, pin_out}, 2'b10);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    opt_ld <= 1'b1;
    @(posedge aclk);
    opt_ld <= 1'b0;
  endtask : pwr_up

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : complete_run

  // ****************************************************************
  // tests
  // ****************************************************************
  initial
  begin
    pwr_up(1'b1);
    repeat (md + 10) @(posedge aclk);
    chk({pin_in, crst}, 2'b01);
    chk({regf, clki}, 2'b11);
    flash <= 1'b1;
    wt_rel();
    chk(pin_in, 1);
    $display("test power-on done");
    hold <= 1'b1;
    repeat (6) @(posedge aclk);
    chk(crst, 1);
    hold <= 1'b0;
    wt_rel();
    rd(flag_addr);
    chk(rdat, one_w << flag_pin_bit);
    wr(enable_addr, one_w << flag_pin_bit);
    chk(irq, 1);
    chk(resp, resp_okay);
    wr(clear_addr, one_w << flag_pin_bit);
    chk(irq, 0);
    rd(8'h40);
    chk(resp, resp_slverr);
    chk(rdat, zero_word);
    wr(8'h40, zero_word);
    chk(resp, resp_slverr);
    $display("test pin reset done");
    wr(ctrl_addr, one_w << ctrl_soft_rst_bit);
    hold <= 1'b1;
    repeat (md + 20) @(posedge aclk);
    chk(crst, 1);
    hold <= 1'b0;
    wt_rel();
    lowp <= 1'b1;
    hold <= 1'b1;
    repeat (6) @(posedge aclk);
    hold <= 1'b0;
    lowp <= 1'b0;
    chk(n_wake, 1);
    wt_rel();
    sysr <= 1'b1;
    @(posedge aclk);
    sysr <= 1'b0;
    repeat (md) @(posedge aclk);
    chk({pin_in, crst}, 2'b01);
    wt_rel();
    $display("test stretch and wake done");
    pwr_up(1'b0);
    wt_rel();
    rd(status_addr);
    chk(rdat[st_pin_en_bit], 0);
    lowp <= 1'b1;
    hold <= 1'b1;
    repeat (6) @(posedge aclk);
    chk(crst, 0);
    chk(n_wake, 1);
    hold <= 1'b0;
    lowp <= 1'b0;
    wr(ctrl_addr, one_w << ctrl_gpio_oe_bit);
    chk({pin_oe, pin_in}, 2'b10);
    wr(ctrl_addr, (one_w << ctrl_gpio_oe_bit) | (one_w << ctrl_gpio_out_bit));
    chk({pin_oe, pin_out}, 2'b11);
    wr(ctrl_addr, one_w << ctrl_soft_rst_bit);
    wt_rel();
    rd(status_addr);
    chk(rdat[st_pin_en_bit], 0);
    sec <= 1'b1;
    wr(debug_addr, one_w << dbg_mass_erase_bit);
    chk(n_erase, 0);
    wr(debug_addr,
       (one_w << dbg_mass_erase_bit) | (one_w << dbg_sys_reset_bit));
    chk(n_erase, 1);
    wt_rel();
    $display("test pin disabled done");
    complete_run();
  end
endmodule : testbench
